// *** pulse_motion_command_core.sv ***
// two-axis pulse motion command core with apb register access
`timescale 1ns/10ps
module pulse_motion_command_core
  import motion_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  sensorIn0,
  input  wire logic [6:0]  sensorIn1,
  input  wire logic [1:0]  driverIn0,
  input  wire logic [1:0]  driverIn1,
  input  wire logic [7:0]  gpIn,
  output logic      [1:0]  stepOut,
  output logic      [1:0]  servoOnOut,
  output logic      [1:0]  devCounterClearOut,
  output logic      [7:0]  gpOut
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    axis_state_t st;
    logic [7:0]  mode;
    logic [7:0]  init;
    logic [23:0] mult;
    logic [23:0] count;
    logic [23:0] decel;
    logic [23:0] maxf;
    logic [23:0] accel;
    logic [23:0] base;
    logic [31:0] cntA;
    logic [31:0] cntB;
    logic [23:0] cntC;
    logic [23:0] cntD;
    logic [23:0] cntF;
    logic        hold;
    logic        slow;
    logic        errFlag;
    logic        doneFlag;
    logic        intFlag;
    logic        servoOn;
    logic        devClr;
  } axis_t;

  typedef struct packed {
    axis_t [1:0] ax;
    logic  [7:0] gp;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } core_t;

  core_t s_q, s_d;
  logic [1:0] step;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_pg
      pulse_gen u_pg (
        .clk    (clk),
        .rst    (rst),
        .enable (s_q.ax[g].st == ST_RUN || s_q.ax[g].st == ST_RAMPD),
        .freq   (s_q.ax[g].cntF),
        .mult   (s_q.ax[g].mult),
        .step   (step[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] status_word(input axis_t a, input logic [6:0] sen,
                                              input logic [1:0] drv);
    logic moving;
    moving = (a.st == ST_RUN) || (a.st == ST_RAMPD);
    // status bits and live inputs [RULE20] [RULE21]
    return {16'h0, drv, sen, a.devClr, a.intFlag, a.doneFlag, a.errFlag,
            moving & (a.slow || a.st == ST_RAMPD) & ~a.hold,
            moving & ~a.slow & ~a.hold & (a.st == ST_RUN) & (a.cntF < a.maxf), moving};
  endfunction : status_word

  // preset allowed only within format range
  function automatic logic preset_ok(input logic [1:0] fmt, input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    if (fmt == 2'b00) ok = (v[31:23] == 9'h000) || (v[31:23] == 9'h1ff);
    else if (fmt == 2'b01) ok = (v[31:24] == 8'h00);
    return ok;
  endfunction : preset_ok

  logic        wrEn;
  logic        rdEn;
  logic        axSel;
  logic [11:0] off;
  logic        hit;
  logic [1:0]  fmt;
  logic [1:0]  decMode;
  logic [23:0] target;
  logic [7:0]  code;
  logic        stopping;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wrEn = psel && penable && pwrite && !s_q.ready;
    rdEn = psel && !penable;
    axSel = paddr[8];
    off = {4'h0, paddr[7:0]};
    hit = 1'b0;
    fmt = 2'b00;
    decMode = 2'b00;
    target = 24'h0;
    code = pwdata[7:0];
    stopping = 1'b0;
    s_d.ready = psel && penable && !s_q.ready;
    s_d.err = 1'b0;

    // per-axis motion progress [RULE23]
    for (int i = 0; i < 2; i++) begin
      decMode = {s_q.ax[i].mode[MODE_DEC_HI_BIT], s_q.ax[i].mode[MODE_DEC_LO_BIT]};
      target = s_q.ax[i].maxf;
      stopping = s_q.ax[i].st == ST_RAMPD;
      if (s_q.ax[i].slow || stopping) target = 24'h000001;
      if (step[i]) begin
        if (s_q.ax[i].cntC != 24'h0) s_d.ax[i].cntC = s_q.ax[i].cntC - 24'h1;
        s_d.ax[i].cntA = s_q.ax[i].cntA + 32'h1;
        if (decMode == DEC_AUTO) s_d.ax[i].cntD = s_q.ax[i].cntD + 24'h1;
        else if (s_q.ax[i].cntD != 24'h0) s_d.ax[i].cntD = s_q.ax[i].cntD - 24'h1;
        if (s_q.ax[i].cntC == 24'h1) begin
          s_d.ax[i].st = ST_IDLE;
          s_d.ax[i].doneFlag = 1'b1;
          s_d.ax[i].intFlag = 1'b1;
          s_d.ax[i].cntF = 24'h0;
        end
      end
      if (s_q.ax[i].st == ST_RUN && decMode != DEC_NONE && decMode != DEC_AUTO &&
          s_q.ax[i].cntC <= s_q.ax[i].cntD)
        target = 24'h000001;
      // frozen speed holds F steady [RULE6]
      if (!s_q.ax[i].hold && s_d.ax[i].st != ST_IDLE && (s_q.ax[i].st == ST_RUN || stopping)) begin
        if (s_q.ax[i].cntF < target) s_d.ax[i].cntF = s_q.ax[i].cntF + 24'h1;
        else if (s_q.ax[i].cntF > target) s_d.ax[i].cntF = s_q.ax[i].cntF - 24'h1;
        else if (stopping) begin
          s_d.ax[i].st = ST_IDLE; // ramp reached floor, stop [RULE10]
          s_d.ax[i].doneFlag = 1'b1;
          s_d.ax[i].cntF = 24'h0;
        end
      end
      s_d.ax[i].cntB = fmt_value({s_q.ax[i].init[INIT_FMT_HI_BIT],
                                  s_q.ax[i].init[INIT_FMT_LO_BIT]}, s_q.ax[i].cntB);
      // both A and B wrap inside their format [RULE12]
      s_d.ax[i].cntA = fmt_value({s_q.ax[i].init[INIT_FMT_HI_BIT],
                                  s_q.ax[i].init[INIT_FMT_LO_BIT]}, s_d.ax[i].cntA);
    end

    // ----------------------------------------------------------------
    // register writes, taken at the access edge
    // ----------------------------------------------------------------
    if (wrEn) begin
      fmt = {s_q.ax[axSel].init[INIT_FMT_HI_BIT], s_q.ax[axSel].init[INIT_FMT_LO_BIT]};
      if (paddr[9]) begin
        hit = 1'b1;
        if (paddr[7:0] == OFF_GP_OUT[7:0]) s_d.gp = pwdata[7:0]; // [RULE19]
        else if (paddr[7:0] == OFF_SYNC[7:0]) begin
          for (int i = 0; i < 2; i++)
            if (s_q.ax[i].st == ST_WAIT) s_d.ax[i].st = ST_RUN; // [RULE2]
        end else if (paddr[7:0] == OFF_ESTOP[7:0]) begin
          for (int i = 0; i < 2; i++) begin
            s_d.ax[i].st = ST_IDLE; // all axes at once [RULE11]
            s_d.ax[i].cntF = 24'h0;
            s_d.ax[i].errFlag = 1'b1;
          end
        end else if (paddr[7:0] == OFF_GP_IN[7:0]) hit = 1'b1;
        else hit = 1'b0;
      end else begin
        hit = 1'b1;
        if (off == OFF_MODE) s_d.ax[axSel].mode = pwdata[7:0];
        else if (off == OFF_MULT) s_d.ax[axSel].mult = pwdata[23:0];
        else if (off == OFF_COUNT) begin
          s_d.ax[axSel].count = pwdata[23:0];
          s_d.ax[axSel].cntC = pwdata[23:0]; // [RULE13]
        end else if (off == OFF_DECEL) begin
          s_d.ax[axSel].decel = pwdata[23:0];
          s_d.ax[axSel].cntD = pwdata[23:0]; // [RULE15]
        end else if (off == OFF_MAXF) s_d.ax[axSel].maxf = pwdata[23:0];
        else if (off == OFF_ACCEL) s_d.ax[axSel].accel = pwdata[23:0];
        else if (off == OFF_BASE) s_d.ax[axSel].base = pwdata[23:0];
        else if (off == OFF_INIT) s_d.ax[axSel].init = pwdata[7:0];
        else if (off == OFF_PRESET_A) begin
          if (preset_ok(fmt, pwdata)) s_d.ax[axSel].cntA = fmt_value(fmt, pwdata); // [RULE18]
          else s_d.err = 1'b1;
        end else if (off == OFF_PRESET_B) begin
          if (preset_ok(fmt, pwdata)) s_d.ax[axSel].cntB = fmt_value(fmt, pwdata); // [RULE18]
          else s_d.err = 1'b1;
        end else if (off == OFF_DRV_BIT) begin
          // bit0 set/clear servo-on, bit1 selects clear output [RULE22]
          if (pwdata[1]) s_d.ax[axSel].devClr = pwdata[0];
          else s_d.ax[axSel].servoOn = pwdata[0];
        end else if (off == OFF_CMD) begin
          // instruction acts on the addressed axis only [RULE23]
          if (code == CMD_START && s_q.ax[axSel].st == ST_IDLE) begin
            // mode and count already written by the host [RULE1]
            s_d.ax[axSel].st = s_q.ax[axSel].mode[MODE_SYNC_BIT] ? ST_WAIT : ST_RUN; // [RULE2]
            s_d.ax[axSel].hold = 1'b0;
            s_d.ax[axSel].slow = 1'b0;
            s_d.ax[axSel].doneFlag = 1'b0;
            if ({s_q.ax[axSel].mode[MODE_DEC_HI_BIT], s_q.ax[axSel].mode[MODE_DEC_LO_BIT]}
                == DEC_AUTO)
              s_d.ax[axSel].cntD = 24'h0; // [RULE16] [RULE14]
          end else if (code == CMD_HARD_STOP) begin
            s_d.ax[axSel].st = ST_IDLE; // no ramp [RULE3]
            s_d.ax[axSel].cntF = 24'h0;
            s_d.ax[axSel].doneFlag = 1'b1;
          end else if (code == CMD_DECEL_STOP) begin
            if (s_q.ax[axSel].st != ST_IDLE) s_d.ax[axSel].st = ST_RAMPD; // [RULE10]
          end else if (code == CMD_DECEL) s_d.ax[axSel].slow = 1'b1; // [RULE8]
          else if (code == CMD_DECEL_REL) s_d.ax[axSel].slow = 1'b0; // [RULE9]
          else if (code == CMD_CONST) s_d.ax[axSel].hold = 1'b1; // [RULE6]
          else if (code == CMD_CONST_REL) s_d.ax[axSel].hold = 1'b0; // [RULE7]
          else if (code == CMD_DONE_RST) begin
            s_d.ax[axSel].doneFlag = s_d.ax[axSel].doneFlag & ~s_q.ax[axSel].doneFlag; // [RULE4]
            s_d.ax[axSel].intFlag = s_d.ax[axSel].intFlag & ~s_q.ax[axSel].intFlag;
            s_d.ax[axSel].errFlag = 1'b0;
            s_d.ax[axSel].count = s_q.ax[axSel].cntC; // [RULE5]
          end else s_d.err = 1'b1;
        end else hit = 1'b0;
      end
      if (!hit) s_d.err = 1'b1;
    end

    // ----------------------------------------------------------------
    // read data captured in setup so it is steady in access
    // ----------------------------------------------------------------
    if (rdEn) begin
      s_d.rdata = 32'h0;
      if (paddr[9]) begin
        if (paddr[7:0] == OFF_GP_OUT[7:0]) s_d.rdata = {24'h0, s_q.gp};
        else if (paddr[7:0] == OFF_GP_IN[7:0]) s_d.rdata = {24'h0, gpIn};
      end else if (off == OFF_MODE) s_d.rdata = {24'h0, s_q.ax[axSel].mode};
      else if (off == OFF_MULT) s_d.rdata = {8'h0, s_q.ax[axSel].mult};
      else if (off == OFF_COUNT) s_d.rdata = {8'h0, s_q.ax[axSel].count};
      else if (off == OFF_DECEL) s_d.rdata = {8'h0, s_q.ax[axSel].decel};
      else if (off == OFF_MAXF) s_d.rdata = {8'h0, s_q.ax[axSel].maxf};
      else if (off == OFF_ACCEL) s_d.rdata = {8'h0, s_q.ax[axSel].accel};
      else if (off == OFF_BASE) s_d.rdata = {8'h0, s_q.ax[axSel].base};
      else if (off == OFF_INIT) s_d.rdata = {24'h0, s_q.ax[axSel].init};
      else if (off == OFF_DRV_BIT)
        s_d.rdata = {30'h0, s_q.ax[axSel].devClr, s_q.ax[axSel].servoOn};
      else if (off == OFF_STATUS)
        s_d.rdata = axSel ? status_word(s_q.ax[1], sensorIn1, driverIn1)
                          : status_word(s_q.ax[0], sensorIn0, driverIn0);
      else if (off == OFF_CNT_A) s_d.rdata = s_q.ax[axSel].cntA;
      else if (off == OFF_CNT_B) s_d.rdata = s_q.ax[axSel].cntB;
      else if (off == OFF_CNT_C) s_d.rdata = {8'h0, s_q.ax[axSel].cntC};
      else if (off == OFF_CNT_D) s_d.rdata = {8'h0, s_q.ax[axSel].cntD};
      else if (off == OFF_CNT_F) s_d.rdata = {8'h0, s_q.ax[axSel].cntF};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.ax[0].st <= ST_IDLE;
      s_q.ax[1].st <= ST_IDLE;
      s_q.ax[0].mult <= MULT_RESET;
      s_q.ax[1].mult <= MULT_RESET;
      s_q.ax[0].maxf <= MAXF_RESET;
      s_q.ax[1].maxf <= MAXF_RESET;
      s_q.ax[0].accel <= ACCEL_RESET;
      s_q.ax[1].accel <= ACCEL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs, each from a flip-flop of the state or the pulse generator
  assign prdata             = s_q.rdata;
  assign pready             = s_q.ready;
  assign pslverr            = s_q.err;
  assign stepOut            = step;
  assign servoOnOut         = {s_q.ax[1].servoOn, s_q.ax[0].servoOn};
  assign devCounterClearOut = {s_q.ax[1].devClr, s_q.ax[0].devClr};
  assign gpOut              = s_q.gp;
endmodule : pulse_motion_command_core

// *** motion_pkg.sv ***
// shared constants, register map and types of the pulse motion command core
// Overview of operation
// RULE1 - host writes mode, count, base, then instruction; the host model start task writes no base
// RULE2 - sync mode waits in standby for sync start
// RULE3 - code 30h stops pulses at once
// RULE4 - code A0h clears completion flag
// RULE5 - code A0h copies remaining count into count
// RULE6 - code 34h freezes speed, no ramping
// RULE7 - code 35h resumes normal ramping
// RULE8 - code 32h starts deceleration while driving
// RULE9 - code 33h cancels commanded deceleration
// RULE10 - code 31h ramps down then stops
// RULE11 - emergency stop halts every axis
// RULE12 - bits 5,6 select counter A/B format
// RULE13 - writing count also loads remaining counter
// RULE14 - two bits select deceleration point mode
// RULE15 - writing decel point loads point counter
// RULE16 - automatic mode clears point counter at start
// RULE17 - pulse rate is 300 times F over ratio
// RULE18 - preset loads A or B within format range
// RULE19 - eight outputs written together
// RULE20 - per-axis status bits reported
// RULE21 - live sensor and driver input levels reported
// RULE22 - servo-on and clear set or cleared per bit
// RULE23 - each axis keeps its own state
package motion_pkg;
  // ----------------------------------------------------------------
  // register byte offsets, axis 2 at AXIS_STRIDE above axis 1
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_MODE       = 12'h000;
  localparam logic [11:0] OFF_MULT       = 12'h004;
  localparam logic [11:0] OFF_COUNT      = 12'h008;
  localparam logic [11:0] OFF_DECEL      = 12'h00c;
  localparam logic [11:0] OFF_MAXF       = 12'h010;
  localparam logic [11:0] OFF_ACCEL      = 12'h014;
  localparam logic [11:0] OFF_BASE       = 12'h018;
  localparam logic [11:0] OFF_CMD        = 12'h01c;
  localparam logic [11:0] OFF_INIT       = 12'h020;
  localparam logic [11:0] OFF_PRESET_A   = 12'h024;
  localparam logic [11:0] OFF_PRESET_B   = 12'h028;
  localparam logic [11:0] OFF_DRV_BIT    = 12'h02c;
  localparam logic [11:0] OFF_STATUS     = 12'h030;
  localparam logic [11:0] OFF_CNT_A      = 12'h034;
  localparam logic [11:0] OFF_CNT_B      = 12'h038;
  localparam logic [11:0] OFF_CNT_C      = 12'h03c;
  localparam logic [11:0] OFF_CNT_D      = 12'h040;
  localparam logic [11:0] OFF_CNT_F      = 12'h044;
  localparam logic [11:0] AXIS_STRIDE    = 12'h100;
  localparam logic [11:0] OFF_GP_OUT     = 12'h200;
  localparam logic [11:0] OFF_SYNC       = 12'h204;
  localparam logic [11:0] OFF_ESTOP      = 12'h208;
  localparam logic [11:0] OFF_GP_IN      = 12'h20c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_SYNC_BIT   = 0;
  localparam int MODE_INTERP_BIT = 1;
  localparam int MODE_DEC_LO_BIT = 2;
  localparam int MODE_DEC_HI_BIT = 3;
  localparam int INIT_FMT_LO_BIT = 6;
  localparam int INIT_FMT_HI_BIT = 5;
  // ----------------------------------------------------------------
  // instruction codes and deceleration point modes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_START      = 8'h10;
  localparam logic [7:0] CMD_HARD_STOP  = 8'h30;
  localparam logic [7:0] CMD_DECEL_STOP = 8'h31;
  localparam logic [7:0] CMD_DECEL      = 8'h32;
  localparam logic [7:0] CMD_DECEL_REL  = 8'h33;
  localparam logic [7:0] CMD_CONST      = 8'h34;
  localparam logic [7:0] CMD_CONST_REL  = 8'h35;
  localparam logic [7:0] CMD_DONE_RST   = 8'ha0;
  localparam logic [1:0] DEC_AUTO       = 2'b00;
  localparam logic [1:0] DEC_OFFSET     = 2'b01;
  localparam logic [1:0] DEC_MANUAL     = 2'b10;
  localparam logic [1:0] DEC_NONE       = 2'b11;
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [23:0] MULT_RESET    = 24'h00012c;
  localparam logic [23:0] MAXF_RESET    = 24'h000064;
  localparam logic [23:0] ACCEL_RESET   = 24'h000001;
  localparam logic [31:0] PPS_FACTOR    = 32'h0000012c;
  localparam int          CLK_HZ        = 125000000;
  localparam int          BASE_TICKS    = CLK_HZ / PPS_FACTOR;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_RAMPD = 4'b1000
  } axis_state_t;

  // sign or zero extend per counter format, returns clipped value
  function automatic logic [31:0] fmt_value(input logic [1:0] fmt, input logic [31:0] v);
    logic [31:0] r;
    r = v;
    if (fmt == 2'b00) r = {{8{v[23]}}, v[23:0]};
    else if (fmt == 2'b01) r = {8'h00, v[23:0]};
    return r;
  endfunction : fmt_value
endpackage : motion_pkg

// *** pulse_gen.sv ***
// phase accumulator producing the step pulse train
`timescale 1ns/10ps
module pulse_gen
  import motion_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic [23:0] freq,
  input  wire logic [23:0] mult,
  output logic             step
);
  typedef struct packed {
    logic [39:0] acc;
    logic        step;
  } pg_state_t;
  pg_state_t s_q, s_d;
  logic [39:0] limit;

  // rate = 300 * F / ratio [RULE17]
  always_comb begin
    limit = {16'h0000, mult} * 40'(BASE_TICKS);
    s_d = s_q;
    s_d.step = 1'b0;
    if (!enable || mult == 24'h000000) begin
      s_d.acc = 40'h0;
    end else if (s_q.acc + 40'(freq) >= limit) begin
      s_d.acc  = s_q.acc + 40'(freq) - limit;
      s_d.step = 1'b1;
    end else begin
      s_d.acc = s_q.acc + 40'(freq);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
  end
  assign step = s_q.step;
endmodule : pulse_gen

// *** pulse_motion_command_core_monitor.sv ***
// port-level checker for the pulse motion command core
`timescale 1ns/10ps
module pulse_motion_command_core_monitor
  import motion_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [6:0]  sensorIn0,
  input wire logic [1:0]  driverIn0,
  input wire logic [7:0]  gpIn,
  input wire logic [1:0]  stepOut,
  input wire logic [1:0]  servoOnOut,
  input wire logic [1:0]  devCounterClearOut,
  input wire logic [7:0]  gpOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----
  // helper terms
  // ----
  logic        wrTake;
  logic        rdSetup;
  logic        fresh_q;
  logic [31:0] lastCount_q;
  assign wrTake  = psel & penable & ~pready & pwrite;
  assign rdSetup = psel & ~penable & ~pwrite;
  // counter c mirrors the count only until a command may move the axis
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fresh_q     <= 1'b0;
      lastCount_q <= 32'h0;
    end else if (wrTake && paddr == OFF_COUNT) begin
      fresh_q     <= 1'b1;
      lastCount_q <= pwdata;
    end else if (wrTake && (paddr == OFF_CMD || paddr[9])) begin
      fresh_q <= 1'b0;
    end
  end
  sequence s_axis1Quiet;
    (!stepOut[1]) [*8];
  endsequence
  sequence s_allQuiet;
    (stepOut == 2'b00) [*8];
  endsequence
  // ----
  // assertions
  // ----
  a_hard_stop_quiet: assert property (wrTake && paddr == (AXIS_STRIDE | OFF_CMD)
    && pwdata[7:0] == CMD_HARD_STOP |-> ##3 s_axis1Quiet)
    else $error("axis 2 stepped after hard stop");
  a_estop_all_quiet: assert property (wrTake && paddr == OFF_ESTOP
    |-> ##3 s_allQuiet)
    else $error("step seen after emergency stop");
  a_gp_out_batch: assert property (wrTake && paddr == OFF_GP_OUT
    |-> ##2 gpOut == $past(pwdata[7:0], 2))
    else $error("general outputs differ from written byte");
  a_servo_bit_op: assert property (wrTake && paddr == OFF_DRV_BIT && !pwdata[1]
    |-> ##2 servoOnOut[0] == $past(pwdata[0], 2)
    && devCounterClearOut == $past(devCounterClearOut, 2))
    else $error("servo-on bit operation wrong");
  a_clear_bit_op: assert property (wrTake && paddr == (AXIS_STRIDE | OFF_DRV_BIT)
    && pwdata[1] |-> ##2 devCounterClearOut[1] == $past(pwdata[0], 2)
    && servoOnOut == $past(servoOnOut, 2))
    else $error("clear bit operation wrong");
  a_sensor_live: assert property (rdSetup && paddr == OFF_STATUS
    |-> ##2 prdata[15:7] == {$past(driverIn0, 2), $past(sensorIn0, 2)})
    else $error("status does not show live inputs");
  a_gp_in_live: assert property (rdSetup && paddr == OFF_GP_IN
    |-> ##2 prdata[7:0] == $past(gpIn, 2))
    else $error("general inputs read wrong");
  a_count_to_c: assert property (rdSetup && paddr == OFF_CNT_C && fresh_q
    |-> ##2 prdata[23:0] == lastCount_q[23:0])
    else $error("counter c not loaded from count");
endmodule : pulse_motion_command_core_monitor

bind pulse_motion_command_core pulse_motion_command_core_monitor i_mon (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .sensorIn0(sensorIn0), .driverIn0(driverIn0), .gpIn(gpIn), .stepOut(stepOut),
  .servoOnOut(servoOnOut), .devCounterClearOut(devCounterClearOut), .gpOut(gpOut));

// *** host_model.sv ***
// apb host model issuing parameters and instruction codes
`timescale 1ns/10ps
module host_model
  import motion_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic      [11:0] paddr = 12'h000,
  output logic      [31:0] pwdata = 32'h0
);
  // ----
  // one transfer, request held until pready is sampled high
  // ----
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // mode first, then count, code last
  task automatic start(input logic [11:0] ax, input logic [31:0] mode, input logic [31:0] n);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, ax | OFF_MODE, mode, q, e);
    xfer(1'b1, ax | OFF_COUNT, n, q, e);
    xfer(1'b1, ax | OFF_CMD, {24'h0, CMD_START}, q, e);
  endtask : start
endmodule : host_model

// *** pulse_motion_command_core_tb.sv ***
// self-checking bench for the pulse motion command core
`timescale 1ns/10ps
module pulse_motion_command_core_tb
  import motion_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, f1;
  logic [6:0]  sensorIn0 = 7'h00, sensorIn1 = 7'h00;
  logic [1:0]  driverIn0 = 2'b00, driverIn1 = 2'b00;
  logic [7:0]  gpIn = 8'h00;
  logic [1:0]  stepOut, servoOnOut, devCounterClearOut;
  logic [7:0]  gpOut;
  int          nFail = 0, samplesChecked = 0, cycles = 0, steps0 = 0, steps1 = 0, s0, s2;
  longint      e;
  logic [31:0] fmtInit [4] = '{32'h0, 32'h40, 32'h20, 32'h60};
  logic [31:0] good [4] = '{32'hffffffff, 32'h00ffffff, 32'h80000000, 32'hffffffff};
  logic [31:0] bad [4] = '{32'h00800000, 32'h01000000, 32'h80000000, 32'hffffffff};
  always #4 clk = ~clk;
  host_model i_host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  pulse_motion_command_core i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sensorIn0(sensorIn0), .sensorIn1(sensorIn1), .driverIn0(driverIn0),
    .driverIn1(driverIn1), .gpIn(gpIn), .stepOut(stepOut), .servoOnOut(servoOnOut),
    .devCounterClearOut(devCounterClearOut), .gpOut(gpOut));
  // ----
  // step counting and hang guard
  // ----
  always @(posedge clk) begin
    steps0 += (stepOut[0] === 1'b1);
    steps1 += (stepOut[1] === 1'b1);
    cycles++;
    if (cycles == 90000) begin
      nFail++;
      testDone();
    end
  end
  // ----
  // access and compare tasks
  // ----
  task automatic testDone();
    if (nFail == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : testDone
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x = 1'b0);
    logic [31:0] q;
    logic        er;
    i_host.xfer(1'b1, a, d, q, er);
    chk({31'h0, er}, {31'h0, x});
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic er;
    i_host.xfer(1'b0, a, 32'h0, v, er);
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    rd(a);
    chk(v, x);
  endtask : rc
  // polls a status bit; bounded so a stuck axis cannot hang the run
  task automatic waitBit(input int b, input logic x);
    int k;
    k = 0;
    rd(OFF_STATUS);
    while (v[b] !== x && k < 6000) begin
      rd(OFF_STATUS);
      k++;
    end
    chk({31'h0, v[b]}, {31'h0, x});
  endtask : waitBit
  task automatic trend(input logic up);
    logic [31:0] f;
    rd(OFF_CNT_F);
    f = v;
    cyc(20);
    rd(OFF_CNT_F);
    chk(32'(up ? (v > f) : (v < f)), 32'h1);
  endtask : trend
  // ----
  // main sequence
  // ----
  initial begin
    cyc(6);
    rst <= 1'b0;
    rc(OFF_MULT, 32'd300);
    wr(12'h3f0, 32'h1, 1'b1);
    wr(OFF_GP_OUT, 32'ha5);
    chk({24'h0, gpOut}, 32'ha5);
    wr(OFF_DRV_BIT, 32'h1);
    wr(AXIS_STRIDE | OFF_DRV_BIT, 32'h3);
    chk({28'h0, devCounterClearOut, servoOnOut}, 32'h9);
    wr(OFF_DRV_BIT, 32'h0);
    chk({28'h0, devCounterClearOut, servoOnOut}, 32'h8);
    sensorIn0 <= 7'h55;
    driverIn0 <= 2'b10;
    sensorIn1 <= 7'h2a;
    driverIn1 <= 2'b01;
    gpIn <= 8'h3c;
    rd(OFF_STATUS);
    chk({23'h0, v[15:7]}, {23'h0, 2'b10, 7'h55});
    rc(OFF_GP_IN, 32'h3c);
    rd(AXIS_STRIDE | OFF_STATUS);
    chk({23'h0, v[15:6]}, {22'h0, 2'b01, 7'h2a, 1'b1});
    wr(OFF_COUNT, 32'd77);
    rc(OFF_CNT_C, 32'd77);
    wr(OFF_DECEL, 32'h123);
    rc(OFF_CNT_D, 32'h123);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_INIT, fmtInit[i]);
      wr(OFF_PRESET_B, good[i]);
      rc(OFF_CNT_B, good[i]);
      wr(OFF_PRESET_B, bad[i], i < 2);
      rc(OFF_CNT_B, good[i]);
    end
    wr(OFF_MULT, 32'd1);
    wr(OFF_MAXF, 32'd10000);
    i_host.start(12'h000, 32'h1, 32'd3);
    cyc(2000);
    chk(32'(steps0), 32'h0);
    wr(OFF_SYNC, 32'h1);
    rc(OFF_CNT_D, 32'h0);
    waitBit(4, 1'b1);
    chk(32'(steps0), 32'd3);
    wr(OFF_CMD, 32'ha0);
    waitBit(4, 1'b0);
    rc(OFF_COUNT, 32'h0);
    i_host.start(12'h000, 32'h0, 32'd1000);
    cyc(600);
    wr(OFF_CMD, 32'h34);
    rd(OFF_CNT_F);
    f1 = v;
    s0 = steps0;
    cyc(25000);
    e = 64'd300 * f1 * 25000 / 125000000;
    s0 = steps0 - s0;
    chk(32'(s0 >= e - 1 && s0 <= e + 1), 32'h1);
    rc(OFF_CNT_F, f1);
    wr(OFF_CMD, 32'h35);
    trend(1'b1);
    wr(OFF_CMD, 32'h32);
    trend(1'b0);
    wr(OFF_CMD, 32'h33);
    trend(1'b1);
    wr(OFF_CMD, 32'h31);
    waitBit(0, 1'b0);
    rd(OFF_CNT_C);
    f1 = v;
    wr(OFF_CMD, 32'ha0);
    rc(OFF_COUNT, f1);
    wr(AXIS_STRIDE | OFF_MULT, 32'd1);
    wr(AXIS_STRIDE | OFF_MAXF, 32'd10000);
    i_host.start(12'h000, 32'h0, 32'd1000);
    i_host.start(AXIS_STRIDE, 32'h0, 32'd1000);
    cyc(3000);
    wr(AXIS_STRIDE | OFF_CMD, 32'h30);
    cyc(4);
    s0 = steps1;
    s2 = steps0;
    cyc(300);
    chk(32'(steps1 - s0), 32'h0);
    chk(32'(steps0 > s2), 32'h1);
    wr(AXIS_STRIDE | OFF_CMD, 32'ha0);
    i_host.start(AXIS_STRIDE, 32'h0, 32'd1000);
    cyc(3000);
    wr(OFF_ESTOP, 32'h1);
    cyc(4);
    s0 = steps0 + steps1;
    cyc(300);
    chk(32'(steps0 + steps1 - s0), 32'h0);
    rd(AXIS_STRIDE | OFF_STATUS);
    chk({31'h0, v[3]}, 32'h1);
    testDone();
  end
endmodule : pulse_motion_command_core_tb
